// ---- design/mic_irq_wave_top.sv ----
// interrupt flags, mask, open-drain request and operating_config register
// assumes event inputs come from datapath logic on the master clock, one-cycle pulses
// except energy_msb_in and zero_cross_in, which are levels
`default_nettype none
module mic_irq_wave_top #(
   parameter int DATA_W = 20
) (
   input  wire logic              core_clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [4:0]        reg_addr_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   input  wire logic [15:0]       reg_wdata_in,
   output logic      [15:0]       reg_rdata_out,
   input  wire logic              energy_msb_in,
   input  wire logic              energy_overflow_in,
   input  wire logic              sag_event_in,
   input  wire logic              no_zero_cross_in,
   input  wire logic              cal_integration_done_in,
   input  wire logic              zero_cross_in,
   input  wire logic              temp_result_ready_in,
   input  wire logic [DATA_W-1:0] power_lowpass_in,
   input  wire logic [DATA_W-1:0] channel1_in,
   input  wire logic [DATA_W-1:0] channel2_in,
   output logic      [DATA_W-1:0] waveform_out,
   output logic      [15:0]       operating_config_out,
   output logic                   factory_test_out,
   output logic                   irq_n_out,
   output logic                   irq_n_oe_out
);
   typedef struct packed {
      logic [15:0] config_reg;
      logic [7:0]  mask;
      logic [7:0]  flags;
      logic        msb_prev;
      logic [15:0] rdata;
      logic        irq_drive;
   } mic_state_type;

   mic_state_type s_q, s_d;
   logic          wave_strobe;
   logic [7:0]    set_vec;

   mic_wave_sampler #(
      .DATA_W (DATA_W)
   ) u_wave (
      .core_clk_in            (core_clk_in),
      .rst_n_in               (rst_n_in),
      .sample_rate_sel_in     (s_q.config_reg[mic_pkg::CFG_RATE_LSB +: 2]),
      .waveform_source_sel_in (s_q.config_reg[mic_pkg::CFG_SRC_LSB +: 2]),
      .power_lowpass_in       (power_lowpass_in),
      .channel1_in            (channel1_in),
      .channel2_in            (channel2_in),
      .waveform_out           (waveform_out),
      .sample_strobe_out      (wave_strobe)
   );

   // event sources, independent of the mask
   always_comb begin
      set_vec = 8'h00;
      set_vec[mic_pkg::BIT_HALF_FULL] = energy_msb_in & ~s_q.msb_prev;
      set_vec[mic_pkg::BIT_SAG]       = sag_event_in | no_zero_cross_in
                                        | (cal_integration_done_in & s_q.config_reg[mic_pkg::CFG_CAL_BIT]);
      set_vec[mic_pkg::BIT_WAVEFORM_SAMPLE_FLAG]      = wave_strobe;
      set_vec[mic_pkg::BIT_TEMP]      = temp_result_ready_in;
      set_vec[mic_pkg::BIT_OVERFLOW]  = energy_overflow_in;
   end

   always_comb begin
      logic [7:0] clr;
      clr = 8'h00;
      s_d = s_q;
      s_d.rdata = 16'h0000;
      s_d.msb_prev = energy_msb_in;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            mic_pkg::ADDR_IRQ_MASK:  s_d.rdata = {8'h00, s_q.mask};
            mic_pkg::ADDR_FLAGS:     s_d.rdata = {8'h00, s_q.flags};
            mic_pkg::ADDR_FLAGS_CLR: begin
               s_d.rdata = {8'h00, s_q.flags};
               clr = 8'hff;
            end
            mic_pkg::ADDR_CONFIG:    s_d.rdata = s_q.config_reg;
            default:                 s_d.rdata = 16'h0000;
         endcase
      end
      if (reg_wr_in) begin
         if (reg_addr_in == mic_pkg::ADDR_IRQ_MASK) begin
            s_d.mask = reg_wdata_in[7:0] & mic_pkg::FLAG_VALID;
         end
         if (reg_addr_in == mic_pkg::ADDR_CONFIG) begin
            s_d.config_reg = reg_wdata_in;
         end
      end
      // a new event in the clearing cycle survives the clear
      s_d.flags = ((s_q.flags & ~clr) | set_vec) & mic_pkg::FLAG_VALID;
      s_d.flags[mic_pkg::BIT_ZX] = zero_cross_in;
      // same positions in flags and mask, so a plain AND pairs them
      s_d.irq_drive = |(s_d.flags & s_d.mask);
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         s_q.config_reg <= mic_pkg::CONFIG_RESET;
         s_q.mask       <= mic_pkg::MASK_RESET;
         s_q.flags      <= mic_pkg::FLAGS_RESET;
         s_q.msb_prev   <= 1'b0;
         s_q.rdata      <= 16'h0000;
         s_q.irq_drive  <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_out        = s_q.rdata;
   assign operating_config_out = s_q.config_reg;
   assign factory_test_out     = s_q.config_reg[mic_pkg::CFG_TEST_BIT];
   // open drain: the pad only ever pulls low, the enable carries the request
   assign irq_n_out            = 1'b0;
   assign irq_n_oe_out         = s_q.irq_drive;

   a_irq_follows: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      irq_n_oe_out == |(s_q.flags & s_q.mask))
      else $error("irq drive disagrees with flags and mask");
   a_half_full: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (energy_msb_in && !s_q.msb_prev) |=> s_q.flags[mic_pkg::BIT_HALF_FULL])
      else $error("half full flag not set on msb rise");
   a_sag_set: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (sag_event_in || no_zero_cross_in) |=> s_q.flags[mic_pkg::BIT_SAG])
      else $error("sag flag not set");
   a_cal_done: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (cal_integration_done_in && s_q.config_reg[mic_pkg::CFG_CAL_BIT]) |=> s_q.flags[mic_pkg::BIT_SAG])
      else $error("calibration end not flagged");
   a_sample_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      wave_strobe |=> s_q.flags[mic_pkg::BIT_WAVEFORM_SAMPLE_FLAG])
      else $error("sample flag not set");
   a_zx_follow: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ##1 s_q.flags[mic_pkg::BIT_ZX] == $past(zero_cross_in))
      else $error("zero cross flag does not follow");
   a_temp_unmasked: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (temp_result_ready_in && s_q.mask == 8'h00 && !reg_wr_in) |=> (s_q.flags[mic_pkg::BIT_TEMP] && !irq_n_oe_out))
      else $error("temperature flag not set while masked");
   a_overflow_set: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      energy_overflow_in |=> s_q.flags[mic_pkg::BIT_OVERFLOW])
      else $error("overflow flag not set");
   a_clear_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_rd_in && reg_addr_in == mic_pkg::ADDR_FLAGS_CLR && set_vec == 8'h00)
      |=> (reg_rdata_out[7:0] == $past(s_q.flags) && (s_q.flags & 8'hef) == 8'h00))
      else $error("clear on read failed");
   a_plain_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_rd_in && reg_addr_in == mic_pkg::ADDR_FLAGS)
      |=> ((s_q.flags & 8'hef) == (($past(s_q.flags) | $past(set_vec)) & 8'hef)))
      else $error("plain status read changed flags");
   a_test_bit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == mic_pkg::ADDR_CONFIG) |=> factory_test_out == $past(reg_wdata_in[15]))
      else $error("test bit not stored");
   a_config_store: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == mic_pkg::ADDR_CONFIG) |=> operating_config_out == $past(reg_wdata_in))
      else $error("config word not stored");
   a_mask_store: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == mic_pkg::ADDR_IRQ_MASK)
      |=> s_q.mask == ($past(reg_wdata_in[7:0]) & mic_pkg::FLAG_VALID))
      else $error("mask not stored in flag layout");
   // unused positions stay zero in both, so the pairing AND never sees a stray bit
   a_unused_zero: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (s_q.flags & ~mic_pkg::FLAG_VALID) == 8'h00 && (s_q.mask & ~mic_pkg::FLAG_VALID) == 8'h00)
      else $error("unused flag or mask bit set");
   a_plain_data: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_rd_in && reg_addr_in == mic_pkg::ADDR_FLAGS) |=> reg_rdata_out == {8'h00, $past(s_q.flags)})
      else $error("plain status read returned wrong flags");

   // flags only fall through a clearing read; bit 4 is a level and is left out
   a_flags_sticky: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !(reg_rd_in && reg_addr_in == mic_pkg::ADDR_FLAGS_CLR)
      |=> (($past(s_q.flags) & ~s_q.flags) & 8'hef) == 8'h00)
      else $error("flag dropped without clearing read");
   a_set_wins: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_rd_in && reg_addr_in == mic_pkg::ADDR_FLAGS_CLR && temp_result_ready_in)
      |=> s_q.flags[mic_pkg::BIT_TEMP])
      else $error("event lost to clearing read");
   a_cal_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (cal_integration_done_in && !s_q.config_reg[mic_pkg::CFG_CAL_BIT] && !sag_event_in
       && !no_zero_cross_in && !reg_rd_in)
      |=> s_q.flags[mic_pkg::BIT_SAG] == $past(s_q.flags[mic_pkg::BIT_SAG]))
      else $error("calibration end flagged outside calibration mode");

   // a mask write in the same cycle would move the target, so it is excluded
   a_irq_raise: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (temp_result_ready_in && s_q.mask[mic_pkg::BIT_TEMP] && !reg_wr_in) |=> irq_n_oe_out)
      else $error("enabled event did not raise irq");
   // zero cross is a live level, so an enabled bit 4 may keep the line low
   a_irq_release: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_rd_in && reg_addr_in == mic_pkg::ADDR_FLAGS_CLR && !reg_wr_in && (set_vec & s_q.mask) == 8'h00
       && !(zero_cross_in && s_q.mask[mic_pkg::BIT_ZX]))
      |=> !irq_n_oe_out)
      else $error("irq held after clearing read");

   c_irq_raised: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) $rose(irq_n_oe_out));
   c_irq_cleared: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_rd_in && reg_addr_in == mic_pkg::ADDR_FLAGS_CLR && irq_n_oe_out) ##1 !irq_n_oe_out);
   c_cal_done: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
      cal_integration_done_in && s_q.config_reg[mic_pkg::CFG_CAL_BIT]);
   c_set_during_clear: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
      reg_rd_in && reg_addr_in == mic_pkg::ADDR_FLAGS_CLR && temp_result_ready_in);
endmodule : mic_irq_wave_top
`default_nettype wire

// ---- design/mic_pkg.sv ----
// constants shared by the metering interrupt and waveform config logic
// assumes one master clock; registers reached through the serial port's decoded access strobes
`default_nettype none
package mic_pkg;
   // register addresses, as carried in the serial communications word
   localparam logic [4:0]  ADDR_IRQ_MASK      = 5'h03;
   localparam logic [4:0]  ADDR_FLAGS         = 5'h04;
   localparam logic [4:0]  ADDR_FLAGS_CLR     = 5'h05;
   localparam logic [4:0]  ADDR_CONFIG        = 5'h06;
   // flag positions, shared by status, clear-on-read status and mask
   localparam int          BIT_HALF_FULL      = 0;
   localparam int          BIT_SAG            = 1;
   localparam int          BIT_WAVEFORM_SAMPLE_FLAG           = 3;
   localparam int          BIT_ZX             = 4;
   localparam int          BIT_TEMP           = 5;
   localparam int          BIT_OVERFLOW       = 7;
   localparam logic [7:0]  FLAG_VALID         = 8'hbb;
   // operating_config fields
   localparam int          CFG_CAL_BIT        = 7;
   localparam int          CFG_RATE_LSB       = 11;
   localparam int          CFG_SRC_LSB        = 13;
   localparam int          CFG_TEST_BIT       = 15;
   // reset values
   localparam logic [15:0] CONFIG_RESET       = 16'h0000;
   localparam logic [7:0]  MASK_RESET         = 8'h00;
   localparam logic [7:0]  FLAGS_RESET        = 8'h00;
   // waveform rate: master clock / (RATE_BASE_DIV << sample_rate_sel)
   localparam int          RATE_BASE_DIV      = 128;
   localparam int          RATE_CNT_W         = 10;
   // waveform_source_sel codes
   localparam logic [1:0]  SRC_POWER_LOWPASS  = 2'h0;
   localparam logic [1:0]  SRC_RESERVED       = 2'h1;
   localparam logic [1:0]  SRC_CHANNEL1       = 2'h2;
   localparam logic [1:0]  SRC_CHANNEL2       = 2'h3;
endpackage : mic_pkg
`default_nettype wire

// ---- design/mic_wave_sampler.sv ----
// waveform register: rate divider and source selection
// assumes sample inputs are on the master clock domain
`default_nettype none
module mic_wave_sampler #(
   parameter int DATA_W = 20
) (
   input  wire logic              core_clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [1:0]        sample_rate_sel_in,
   input  wire logic [1:0]        waveform_source_sel_in,
   input  wire logic [DATA_W-1:0] power_lowpass_in,
   input  wire logic [DATA_W-1:0] channel1_in,
   input  wire logic [DATA_W-1:0] channel2_in,
   output logic      [DATA_W-1:0] waveform_out,
   output logic                   sample_strobe_out
);
   typedef struct packed {
      logic [mic_pkg::RATE_CNT_W-1:0] cnt;
      logic [DATA_W-1:0]              wave;
      logic                           strobe;
   } mic_wave_state_type;

   mic_wave_state_type s_q, s_d;
   logic [mic_pkg::RATE_CNT_W-1:0] terminal;

   // 128/256/512/1024 master clocks per sample
   assign terminal = mic_pkg::RATE_CNT_W'((mic_pkg::RATE_BASE_DIV << sample_rate_sel_in) - 1);

   always_comb begin
      s_d = s_q;
      s_d.strobe = 1'b0;
      // >= so a faster rate picked mid-period does not wrap the counter
      if (s_q.cnt >= terminal) begin
         s_d.cnt = '0;
         s_d.strobe = 1'b1;
         unique case (waveform_source_sel_in)
            mic_pkg::SRC_POWER_LOWPASS: s_d.wave = power_lowpass_in;
            mic_pkg::SRC_CHANNEL1:      s_d.wave = channel1_in;
            mic_pkg::SRC_CHANNEL2:      s_d.wave = channel2_in;
            mic_pkg::SRC_RESERVED:      s_d.wave = '0;
         endcase
      end else begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign waveform_out      = s_q.wave;
   assign sample_strobe_out = s_q.strobe;

   // helper: cycles since last strobe, and whether the rate moved meanwhile
   logic [mic_pkg::RATE_CNT_W:0] gap_q;
   logic                         rate_moved_q;
   logic [1:0]                   rate_prev_q;
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         gap_q        <= '0;
         rate_moved_q <= 1'b1;
         rate_prev_q  <= 2'h0;
      end else begin
         rate_prev_q <= sample_rate_sel_in;
         gap_q       <= s_q.strobe ? (mic_pkg::RATE_CNT_W+1)'(1) : gap_q + 1'b1;
         rate_moved_q <= s_q.strobe ? 1'b0 : (rate_moved_q | (rate_prev_q != sample_rate_sel_in));
      end
   end

   a_rate_period: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (s_q.strobe && !rate_moved_q && rate_prev_q == sample_rate_sel_in && gap_q != 0)
      |-> (gap_q == (mic_pkg::RATE_CNT_W+1)'(mic_pkg::RATE_BASE_DIV << sample_rate_sel_in)))
      else $error("waveform strobe period wrong");
   a_source_ch1: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (s_q.cnt >= terminal && waveform_source_sel_in == mic_pkg::SRC_CHANNEL1)
      |=> (s_q.strobe && waveform_out == $past(channel1_in)))
      else $error("channel 1 sample not loaded");
   a_source_power: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (s_q.cnt >= terminal && waveform_source_sel_in == mic_pkg::SRC_POWER_LOWPASS)
      |=> (waveform_out == $past(power_lowpass_in)))
      else $error("power sample not loaded");
   c_slow_rate: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
      s_q.strobe && sample_rate_sel_in == 2'h3 && gap_q == 11'h400);
endmodule : mic_wave_sampler
`default_nettype wire

// ---- tb/mic_host_model.sv ----
// host controller model: register strobes and open-drain request pin
// assumes the design samples strobes and address on the rising edge of core_clk_in
`default_nettype none
module mic_host_model (
   input  wire logic        core_clk_in,
   input  wire logic [15:0] reg_rdata_in,
   input  wire logic        irq_n_in,
   input  wire logic        irq_n_oe_in,
   output logic      [4:0]  reg_addr_out,
   output logic             reg_wr_out,
   output logic             reg_rd_out,
   output logic      [15:0] reg_wdata_out,
   output logic             irq_line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // pull-up holds the wire high when nobody sinks it
   assign irq_line_out = irq_n_oe_in ? irq_n_in : 1'b1;
   initial begin
      reg_addr_out = 5'h1f;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_wdata_out = 16'h0000;
   end
   task automatic access(input logic [4:0] a, input logic wr, input logic [15:0] d, output logic [15:0] q);
      @(posedge core_clk_in);
      reg_addr_out <= a;
      reg_wr_out <= wr;
      reg_rd_out <= !wr;
      reg_wdata_out <= d;
      @(posedge core_clk_in);
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      // idle bus carries junk, not the last address
      reg_addr_out <= ~a;
      reg_wdata_out <= ~d;
      // read data stands for the cycle after the read edge: take it at the next edge
      @(posedge core_clk_in);
      q = reg_rdata_in;
   endtask : access
   // status first, then the clearing read
   task automatic service(output logic [15:0] st, output logic [15:0] clr);
      access(5'h04, 1'b0, 16'h0000, st);
      access(5'h05, 1'b0, 16'h0000, clr);
   endtask : service
endmodule : mic_host_model
`default_nettype wire

// ---- tb/meter_irq_and_wave_config_test.sv ----
// self-checking bench for the metering interrupt flags and waveform config
// assumes mic_host_model as the register master on the same clock
`default_nettype none
module meter_irq_and_wave_config_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        msb = 1'b0, ovf = 1'b0, sag = 1'b0, nzc = 1'b0, cal = 1'b0, zc = 1'b0, temp = 1'b0;
   logic [15:0] cnt = 16'h0000;
   logic [4:0]  addr;
   logic        wr, rd, irq_n, irq_oe, irq_line, ftest;
   logic [15:0] wdata, rdata, q, q2, cfg;
   logic [19:0] wave;
   int          miscompares = 0;
   int          n_checks = 0;
   int          n;
   logic [7:0]  exp_bits [0:5] = '{8'h01, 8'h80, 8'h02, 8'h02, 8'h20, 8'h02};
   logic [1:0]  src_tab [0:3] = '{2'h0, 2'h2, 2'h3, 2'h2};
   logic [3:0]  tag_tab [0:3] = '{4'h1, 4'h2, 4'h3, 4'h2};

   mic_irq_wave_top dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .energy_msb_in(msb),
      .energy_overflow_in(ovf), .sag_event_in(sag), .no_zero_cross_in(nzc), .cal_integration_done_in(cal),
      .zero_cross_in(zc), .temp_result_ready_in(temp), .power_lowpass_in({4'h1, cnt}),
      .channel1_in({4'h2, cnt}), .channel2_in({4'h3, cnt}), .waveform_out(wave), .operating_config_out(cfg),
      .factory_test_out(ftest), .irq_n_out(irq_n), .irq_n_oe_out(irq_oe));
   mic_host_model host_u (.core_clk_in(clk), .reg_rdata_in(rdata), .irq_n_in(irq_n), .irq_n_oe_in(irq_oe),
      .reg_addr_out(addr), .reg_wr_out(wr), .reg_rd_out(rd), .reg_wdata_out(wdata), .irq_line_out(irq_line));

   initial begin
      forever #4 clk = ~clk;
   end
   // sources move every cycle so each waveform load is visible
   always @(posedge clk) cnt <= cnt + 16'h0001;

   task automatic final_report;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   task automatic chk_val(input logic [19:0] got, input logic [19:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: value %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      host_u.access(a, 1'b1, d, q);
   endtask : wr_reg
   // bit 3 is masked: waveform loads set it at any moment
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
      host_u.access(a, 1'b0, 16'h0000, q);
      chk_val({4'h0, q & 16'hfff7}, {4'h0, e & 16'hfff7});
   endtask : rd_chk
   task automatic pulse(input int k);
      @(posedge clk);
      case (k)
         0: msb <= 1'b1;
         1: ovf <= 1'b1;
         2: sag <= 1'b1;
         3: nzc <= 1'b1;
         4: temp <= 1'b1;
         default: cal <= 1'b1;
      endcase
      @(posedge clk);
      {msb, ovf, sag, nzc, temp, cal} <= 6'h00;
      #1;
   endtask : pulse
   task automatic wait_change(output int cyc);
      logic [19:0] w;
      cyc = 0;
      w = wave;
      do begin
         @(negedge clk);
         cyc++;
      end while (wave === w && cyc < 2100);
      if (cyc >= 2100) begin
         miscompares++;
         $display("mismatch at %0t: waveform never updated", $time);
         final_report();
      end
   endtask : wait_change

   task automatic t_reset_layout;
      rd_chk(5'h06, 16'h0000);
      rd_chk(5'h03, 16'h0000);
      rd_chk(5'h04, 16'h0000);
      wr_reg(5'h03, 16'hffff);
      rd_chk(5'h03, 16'h00bb);
      rd_chk(5'h1f, 16'h0000);
      wr_reg(5'h03, 16'h0000);
   endtask : t_reset_layout
   task automatic t_events;
      pulse(5);
      rd_chk(5'h04, 16'h0000);
      wr_reg(5'h06, 16'h0080);
      for (int k = 0; k < 6; k++) begin
         pulse(k);
         rd_chk(5'h04, {8'h00, exp_bits[k]});
         rd_chk(5'h04, {8'h00, exp_bits[k]});
         rd_chk(5'h05, {8'h00, exp_bits[k]});
         rd_chk(5'h04, 16'h0000);
         chk_bit(irq_line, 1'b1);
      end
      wr_reg(5'h06, 16'h0000);
   endtask : t_events
   task automatic t_irq;
      wr_reg(5'h03, 16'h0020);
      pulse(1);
      chk_bit(irq_line, 1'b1);
      pulse(4);
      chk_bit(irq_line, 1'b0);
      host_u.service(q2, q);
      chk_val({4'h0, q2 & 16'hfff7}, 20'h000a0);
      chk_val({4'h0, q & 16'hfff7}, 20'h000a0);
      chk_bit(irq_line, 1'b1);
      // event and clearing read land on one edge: the event must survive
      fork
         host_u.access(5'h05, 1'b0, 16'h0000, q);
         pulse(4);
      join
      chk_val({4'h0, q & 16'hfff7}, 20'h00000);
      rd_chk(5'h04, 16'h0020);
      chk_bit(irq_line, 1'b0);
      rd_chk(5'h05, 16'h0020);
      chk_bit(irq_line, 1'b1);
      wr_reg(5'h03, 16'h0000);
   endtask : t_irq
   task automatic t_zero_cross;
      @(posedge clk);
      zc <= 1'b1;
      rd_chk(5'h04, 16'h0010);
      rd_chk(5'h05, 16'h0010);
      rd_chk(5'h04, 16'h0010);
      @(posedge clk);
      zc <= 1'b0;
      rd_chk(5'h04, 16'h0000);
   endtask : t_zero_cross
   task automatic t_wave;
      for (int s = 0; s < 4; s++) begin
         wr_reg(5'h06, {1'b0, src_tab[s], s[1:0], 11'h000});
         wait_change(n);
         wait_change(n);
         wait_change(n);
         chk_val(n[19:0], 20'd128 << s);
         chk_val({16'h0000, wave[19:16]}, {16'h0000, tag_tab[s]});
      end
      host_u.access(5'h04, 1'b0, 16'h0000, q);
      chk_bit(q[3], 1'b1);
      wr_reg(5'h06, 16'h2000);
      repeat (300) @(posedge clk);
      chk_val(wave, 20'h00000);
   endtask : t_wave
   task automatic t_test_bit;
      wr_reg(5'h06, 16'h8000);
      chk_bit(ftest, 1'b1);
      chk_val({4'h0, cfg}, 20'h08000);
      rd_chk(5'h06, 16'h8000);
      wr_reg(5'h06, 16'h0000);
      chk_bit(ftest, 1'b0);
      chk_val({4'h0, cfg}, 20'h00000);
   endtask : t_test_bit

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_layout();
      t_events();
      t_irq();
      t_zero_cross();
      t_wave();
      t_test_bit();
      final_report();
   end
endmodule : meter_irq_and_wave_config_test
`default_nettype wire
